// file: cmr_mult.sv
/*
 * 56x56 multiplier cascaded from 8x8 slices, serial-parallel or fully
 * parallel, plus one registered stand-alone slice with rounding.
 * assumes synchronous inputs on clk and a host that keeps rounding
 * off when it consumes the whole 16-bit slice product.
 */
`include "cmr_cfg.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - operand bit 7 is sign when control high
// - both selects low disable rounding
// - unsigned rounding keeps product bits 15..8
// - signed rounding keeps product bits 14..7
// - rounding injects one below kept field
// - both selects high add three mid-product
// - serial form: seven slices, seven cycles
// - first cycle loads low byte partial product
// - later bytes add in, shifted eight more
// - parallel form: seven ranks, forty-nine slices
// - high-half-only option uses thirty-four slices
// - slice high byte adds next slice low byte
// - rank adder carries through to top
// - lowest rank byte bypasses rank adder
module cmr_mult #(
    parameter int N         = `CMR_SLICES,
    parameter bit PARALLEL  = 1'b0,
    parameter bit HIGH_ONLY = 1'b0
) (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic [7:0]        s_a,
    input  wire logic [7:0]        s_b,
    input  wire cmr_pkg::cmr_ctl_t s_ctl,
    output logic [15:0]            s_prod,
    input  wire logic              start,
    input  wire logic [8*N-1:0]    mcand,
    input  wire logic [8*N-1:0]    mplier,
    output logic [16*N-1:0]        product,
    output logic                   busy,
    output logic                   done
);

    localparam int W = 8 * N;
    localparam cmr_pkg::cmr_ctl_t CTL_PLAIN = '0;  // cascade is unsigned, unrounded

    // combine one rank of slice products
    function automatic logic [W+7:0] rank_sum(input logic [16*N-1:0] p);
        logic [W-1:0] hi;
        logic [W-1:0] lo;
        hi = '0;
        lo = '0;
        for (int j = 0; j < N; j++) begin
            hi[8*j +: 8] = p[16*j+8 +: 8];
            if (j > 0) begin
                lo[8*(j-1) +: 8] = p[16*j +: 8];
            end
        end
        // one rank-wide adder, carry runs to the top byte
        rank_sum = {hi + lo, p[7:0]};
    endfunction : rank_sum

    ////////////////////////////////////////////////////////////////////////////
    // stand-alone slice, registered
    wire logic [15:0] s_comb;

    cmr_slice u_single (
        .a    (s_a),
        .b    (s_b),
        .ctl  (s_ctl),
        .prod (s_comb)
    );

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_prod <= '0;
        end else begin
            s_prod <= s_comb;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    generate
        if (!PARALLEL) begin : g_serial
            cmr_pkg::cmr_state_t state;
            logic [2:0]      cnt;
            logic [W-1:0]    mc;
            logic [W-1:0]    mp;
            logic [2*W-1:0]  acc;
            wire logic [7:0]     digit;
            wire logic [16*N-1:0] sp;
            wire logic [W+7:0]   rank;
            wire logic [2*W-1:0] shifted;
            wire logic [2*W-1:0] next_acc;
            wire logic           last;

            assign digit = mp[8*cnt +: 8];
            for (genvar j = 0; j < N; j++) begin : g_rank
                cmr_slice u_sl (
                    .a    (mc[8*j +: 8]),
                    .b    (digit),
                    .ctl  (CTL_PLAIN),
                    .prod (sp[16*j +: 16])
                );
            end
            assign rank     = rank_sum(sp);
            assign shifted  = (2*W)'(rank) << {cnt, 3'h0};
            // first cycle loads, so no stale sum from the last product
            assign next_acc = (cnt == `CMR_CNT_RST) ? shifted
                                                    : acc + shifted;
            assign last     = (cnt == 3'(N - 1));

            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    state   <= cmr_pkg::CMR_IDLE;
                    cnt     <= `CMR_CNT_RST;
                    mc      <= '0;
                    mp      <= '0;
                    acc     <= '0;
                    product <= '0;
                    busy    <= `CMR_FLAG_RST;
                    done    <= `CMR_FLAG_RST;
                end else begin
                    done <= 1'b0;
                    unique case (state)
                        cmr_pkg::CMR_IDLE: begin
                            if (start) begin
                                mc    <= mcand;
                                mp    <= mplier;
                                cnt   <= `CMR_CNT_RST;
                                busy  <= 1'b1;
                                state <= cmr_pkg::CMR_RUN;
                            end
                        end
                        cmr_pkg::CMR_RUN: begin
                            acc <= next_acc;
                            cnt <= cnt + 3'h1;
                            if (last) begin
                                product <= next_acc;
                                done    <= 1'b1;
                                busy    <= 1'b0;
                                state   <= cmr_pkg::CMR_IDLE;
                            end
                        end
                    endcase
                end
            end

            // rank output is mcand times the current multiplier byte
            rank_val_a: assert property (@(posedge clk) disable iff (!rstn)
                state == cmr_pkg::CMR_RUN |-> rank == (W+8)'(mc) * (W+8)'(digit))
                else $error("rank sum wrong");
            first_load_a: assert property (@(posedge clk) disable iff (!rstn)
                state == cmr_pkg::CMR_RUN && cnt == 3'h0 |=> acc == (2*W)'($past(rank)))
                else $error("first partial product not loaded");
            ser_timing_a: assert property (@(posedge clk) disable iff (!rstn)
                start && state == cmr_pkg::CMR_IDLE |=> busy && !done [*7] ##1 done && !busy)
                else $error("serial product not done in seven cycles");
            ser_value_a: assert property (@(posedge clk) disable iff (!rstn)
                done |-> product == (2*W)'(mc) * (2*W)'(mp))
                else $error("serial product wrong");
            ser_done_c: cover property (@(posedge clk) disable iff (!rstn) done);
        end else begin : g_parallel
            wire logic [16*N-1:0] pp [N];
            wire logic [W+7:0]    rk [N];
            logic [2*W-1:0]       next_product;

            for (genvar i = 0; i < N; i++) begin : g_rank
                for (genvar j = 0; j < N; j++) begin : g_sl
                    // slices with i + j of 4 or less vanish when only the top half is read
                    if (HIGH_ONLY && (i + j <= `CMR_LOW_DROP_SUM)) begin : g_off
                        assign pp[i][16*j +: 16] = 16'h0000;
                    end else begin : g_on
                        cmr_slice u_sl (
                            .a    (mcand[8*j +: 8]),
                            .b    (mplier[8*i +: 8]),
                            .ctl  (CTL_PLAIN),
                            .prod (pp[i][16*j +: 16])
                        );
                    end
                end
                assign rk[i] = rank_sum(pp[i]);
            end

            // rank i weighted like cycle i of the serial form
            always_comb begin
                next_product = '0;
                for (int i = 0; i < N; i++) begin
                    next_product = next_product + ((2*W)'(rk[i]) << (8 * i));
                end
            end

            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    product <= '0;
                    busy    <= `CMR_FLAG_RST;
                    done    <= `CMR_FLAG_RST;
                end else begin
                    busy <= 1'b0;
                    done <= start;
                    if (start) begin
                        product <= next_product;
                    end
                end
            end

            par_value_a: assert property (@(posedge clk) disable iff (!rstn)
                start && !HIGH_ONLY
                |=> done && product == (2*W)'($past(mcand)) * (2*W)'($past(mplier)))
                else $error("parallel product wrong");
            par_low_a: assert property (@(posedge clk) disable iff (!rstn)
                start && !HIGH_ONLY |=> product[7:0] == 8'($past(mcand[7:0]) * $past(mplier[7:0])))
                else $error("low byte bypass wrong");
            par_done_c: cover property (@(posedge clk) disable iff (!rstn) done);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // stand-alone slice checks
    wire logic plain_ops;
    assign plain_ops = !s_ctl.a_signed && !s_ctl.b_signed;

    no_round_a: assert property (@(posedge clk) disable iff (!rstn)
        plain_ops && !s_ctl.rnd_s && !s_ctl.rnd_u
        |=> s_prod == 16'($past(s_a)) * 16'($past(s_b)))
        else $error("unrounded product wrong");
    signed_mul_a: assert property (@(posedge clk) disable iff (!rstn)
        s_ctl == 4'hc
        |=> s_prod == 16'($signed($past(s_a))) * 16'($signed($past(s_b))))
        else $error("signed product wrong");
    round_u_a: assert property (@(posedge clk) disable iff (!rstn)
        plain_ops && s_ctl.rnd_u && !s_ctl.rnd_s
        |=> s_prod == 16'($past(s_a)) * 16'($past(s_b)) + 16'h0080)
        else $error("unsigned rounding wrong");
    round_s_a: assert property (@(posedge clk) disable iff (!rstn)
        plain_ops && s_ctl.rnd_s && !s_ctl.rnd_u
        |=> s_prod == 16'($past(s_a)) * 16'($past(s_b)) + 16'h0040)
        else $error("signed rounding wrong");
    round_both_a: assert property (@(posedge clk) disable iff (!rstn)
        plain_ops && s_ctl.rnd_s && s_ctl.rnd_u
        |=> s_prod == 16'($past(s_a)) * 16'($past(s_b)) + 16'h00c0)
        else $error("double rounding wrong");

    round_u_c: cover property (@(posedge clk) disable iff (!rstn) s_ctl.rnd_u && !s_ctl.rnd_s);
    signed_c:  cover property (@(posedge clk) disable iff (!rstn) s_ctl.a_signed && s_ctl.b_signed);

endmodule : cmr_mult

`default_nettype wire

// file: cmr_cfg.svh
/*
 * constants for the cascaded multiplier: slice geometry, rounding
 * positions, reset values. assumes inclusion by the slice and cascade files.
 */
`ifndef CMR_CFG_SVH
`define CMR_CFG_SVH

`define CMR_SLICE_W      8
`define CMR_SLICES       7
`define CMR_RND_U_BIT    7
`define CMR_RND_S_BIT    6
`define CMR_LOW_DROP_SUM 4
`define CMR_CNT_RST      3'h0
`define CMR_FLAG_RST     1'b0

`endif

// file: cmr_pkg.sv
/*
 * types shared by the slice and the cascade.
 * assumes nothing beyond a systemverilog compiler.
 */
`default_nettype none

package cmr_pkg;

    // per-slice interpretation and rounding controls
    typedef struct packed {
        logic a_signed;
        logic b_signed;
        logic rnd_s;
        logic rnd_u;
    } cmr_ctl_t;

    typedef enum logic {CMR_IDLE, CMR_RUN} cmr_state_t;

endpackage : cmr_pkg

`default_nettype wire

// file: cmr_slice.sv
/*
 * one 8x8 flow-through multiplier slice with rounding injection.
 * assumes cmr_cfg.svh and cmr_pkg; purely combinational, no clock.
 */
`include "cmr_cfg.svh"
`default_nettype none

module cmr_slice (
    input  wire logic [7:0]       a,
    input  wire logic [7:0]       b,
    input  wire cmr_pkg::cmr_ctl_t ctl,
    output logic [15:0]           prod
);

    wire logic signed [8:0]  ax;
    wire logic signed [8:0]  bx;
    wire logic signed [17:0] full;
    wire logic [15:0]        rnd_vec;

    // high control makes bit 7 a sign bit, low keeps it a magnitude bit
    assign ax = {ctl.a_signed & a[7], a};
    assign bx = {ctl.b_signed & b[7], b};
    assign full = ax * bx;
    // single one just below the kept field; both selects add three
    assign rnd_vec = (16'(ctl.rnd_u) << `CMR_RND_U_BIT)
                   + (16'(ctl.rnd_s) << `CMR_RND_S_BIT);
    assign prod = full[15:0] + rnd_vec;

endmodule : cmr_slice

`default_nettype wire

// file: cmr_fpu_src.sv
/*
 * operand and control source standing in for the floating-point logic.
 * assumes it is called from the bench at falling clock edges only.
 */
`default_nettype none

module cmr_fpu_src (
    input  wire logic             clk,
    input  wire logic             busy,
    output var logic              start,
    output var logic [55:0]       mcand,
    output var logic [55:0]       mplier,
    output var logic [7:0]        s_a,
    output var logic [7:0]        s_b,
    output var cmr_pkg::cmr_ctl_t s_ctl
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        start  = 1'b0;
        mcand  = 56'h0;
        mplier = 56'h0;
        s_a    = 8'h00;
        s_b    = 8'h00;
        s_ctl  = 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // waits at falling edges for the serial cascade to go idle; a stuck busy ends in the
    // bench timeout
    task automatic wait_free(input bit wait_idle);
        while (wait_idle && busy !== 1'b0) begin
            @(negedge clk);
        end
    endtask : wait_free

    // holds start and operands up to the next falling edge
    task automatic op(input logic [55:0] mc, input logic [55:0] mp);
        start  = 1'b1;
        mcand  = mc;
        mplier = mp;
        @(negedge clk);
    endtask : op

    // operands only count at the start edge, so they are scrambled afterwards
    task automatic idle;
        start  = 1'b0;
        mcand  = ~mcand;
        mplier = ~mplier;
        @(negedge clk);
    endtask : idle

    // rounding on is only meant for a kept byte; the bench still checks all 16 bits
    task automatic slice(input logic [7:0] a, input logic [7:0] b, input cmr_pkg::cmr_ctl_t c);
        s_a   = a;
        s_b   = b;
        s_ctl = c;
    endtask : slice
endmodule : cmr_fpu_src

`default_nettype wire

// file: cmr_mult_bench.sv
/*
 * self-checking bench: serial and parallel cascades side by side plus the slice.
 * assumes cmr_pkg compiled first and the partner source in cmr_fpu_src.
 */
`default_nettype none
`define CMR_CHECK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin \
    n_errors++; $display("unexpected %s expected %h seen %h", what, exp, got); end end

module cmr_mult_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [111:0] p; int c;} cmr_exp_t;
    logic              clk, rstn, start, busy, done, busy_p, done_p, done_h;
    logic [55:0]       mcand, mplier, mc, mp;
    logic [111:0]      product, product_p, product_h;
    logic [111:0]      q_hi[$];
    logic [7:0]        s_a, s_b;
    cmr_pkg::cmr_ctl_t s_ctl;
    logic [15:0]       s_prod, s_prod_p;
    int                n_errors, tests_run, cyc, seed;
    bit                slice_on;
    cmr_exp_t          q_ser[$], q_par[$];
    logic [15:0]       q_slc[$];

    cmr_mult u_cmr_mult (.clk, .rstn, .s_a, .s_b, .s_ctl, .s_prod, .start, .mcand, .mplier,
        .product, .busy, .done);
    cmr_mult #(.PARALLEL(1'b1)) u_cmr_mult_par (.clk, .rstn, .s_a, .s_b, .s_ctl,
        .s_prod(s_prod_p), .start, .mcand, .mplier, .product(product_p), .busy(busy_p),
        .done(done_p));
    cmr_mult #(.PARALLEL(1'b1), .HIGH_ONLY(1'b1)) u_cmr_mult_hi (.clk, .rstn, .s_a, .s_b,
        .s_ctl, .s_prod(), .start, .mcand, .mplier, .product(product_h), .busy(),
        .done(done_h));
    cmr_fpu_src u_cmr_fpu_src (.clk, .busy, .start, .mcand, .mplier, .s_a, .s_b, .s_ctl);

    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] slice_exp(logic [7:0] a, logic [7:0] b,
                                              cmr_pkg::cmr_ctl_t c);
        logic signed [16:0] x, y;
        x = c.a_signed ? {{9{a[7]}}, a} : {9'h000, a};
        y = c.b_signed ? {{9{b[7]}}, b} : {9'h000, b};
        return 16'(x * y) + (c.rnd_u ? 16'h0080 : 16'h0000)
            + (c.rnd_s ? 16'h0040 : 16'h0000);
    endfunction : slice_exp

    task automatic go(logic [55:0] a, logic [55:0] b, bit ser, bit wt);
        u_cmr_fpu_src.wait_free(wt);
        // noted before driving: the parallel answer stands right after the next edge
        if (ser) q_ser.push_back('{112'(a) * 112'(b), cyc + 8});
        q_par.push_back('{112'(a) * 112'(b), cyc + 1});
        q_hi.push_back(112'(a) * 112'(b));
        u_cmr_fpu_src.op(a, b);
    endtask : go

    task automatic chk(string nm, ref cmr_exp_t q[$], input logic d, input logic [111:0] p);
        cmr_exp_t e;
        if (d !== 1'b0) begin
            if (q.size() == 0) `CMR_CHECK(nm, 1'b0, d)
            else begin
                e = q.pop_front();
                `CMR_CHECK(nm, e.p, p)
                `CMR_CHECK("done cycle", e.c, cyc)
            end
        end
    endtask : chk

    task automatic drain;
        int k;
        k = 0;
        while ((q_ser.size() + q_par.size()) > 0 && k < 40) begin
            @(negedge clk);
            k++;
        end
        u_cmr_fpu_src.idle();
    endtask : drain

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////////
    // slice driver and all result watchers
    always @(negedge clk) begin
        logic [7:0] a, b;
        if (slice_on) begin
            a = 8'($random(seed));
            b = 8'($random(seed));
            u_cmr_fpu_src.slice(a, b, cmr_pkg::cmr_ctl_t'(4'($random(seed))));
            q_slc.push_back(slice_exp(a, b, s_ctl));
        end
    end

    always @(posedge clk) begin
        logic [15:0]  s;
        logic [111:0] hx;
        logic [55:0]  hd;
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            $display("timeout reached");
            print_verdict();
        end
        #1;
        if (rstn === 1'b1) begin
            if (q_slc.size() > 0) begin
                s = q_slc.pop_front();
                `CMR_CHECK("slice product", s, s_prod)
                `CMR_CHECK("par slice product", s, s_prod_p)
            end
            chk("serial product", q_ser, done, product);
            chk("parallel product", q_par, done_p, product_p);
            if (done_h !== 1'b0 && q_hi.size() > 0) begin
                hx = q_hi.pop_front();
                // dropped low slices may cost at most one carry into the top half
                hd = hx[111:56] - product_h[111:56];
                `CMR_CHECK("high half product", 1'b1, hd <= 56'h1)
            end
        end
    end

    initial begin
        seed = 6978;
        rstn = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        `CMR_CHECK("reset product", 112'h0, product)
        `CMR_CHECK("reset busy", 1'b0, busy)
        `CMR_CHECK("reset done", 1'b0, done)
        `CMR_CHECK("reset slice", 16'h0000, s_prod)
        $display("test reset values finished");
        @(negedge clk);
        rstn = 1'b1;
        @(posedge clk);
        slice_on = 1'b1;
        @(negedge clk);
        for (int i = 0; i < 8; i++) begin
            mc = 56'({$random(seed), $random(seed)});
            mp = 56'({$random(seed), $random(seed)});
            if (i == 0) mp = 56'h0;
            if (i == 1) {mc, mp} = {112{1'b1}};
            if (i == 2) mp = 56'hff000000000000;
            go(mc, mp, 1'b1, 1'b1);
            u_cmr_fpu_src.idle();
        end
        drain();
        $display("test serial back to back finished");
        go(56'({$random(seed), $random(seed)}), 56'hffffffffffffff, 1'b1, 1'b1);
        for (int i = 0; i < 3; i++) begin
            go(56'({$random(seed), $random(seed)}), 56'({$random(seed), $random(seed)}),
                1'b0, 1'b0);
        end
        u_cmr_fpu_src.idle();
        repeat (3) go(56'h0, 56'h0, 1'b0, 1'b0);
        u_cmr_fpu_src.idle();
        drain();
        $display("test start burst while busy finished");
        @(posedge clk);
        slice_on = 1'b0;
        repeat (2) @(negedge clk);
        `CMR_CHECK("pending results", 0, q_ser.size() + q_par.size() + q_slc.size())
        `CMR_CHECK("pending high half", 0, q_hi.size())
        `CMR_CHECK("parallel busy", 1'b0, busy_p)
        $display("test slice random modes finished");
        print_verdict();
    end
endmodule : cmr_mult_bench

`default_nettype wire
